// ---- core/hcif_irq_ctrl.sv ----
/*
  Host processor interrupt flags and enable mask, driving interrupt output one.
  Assumes the command port strobes are one-cycle pulses synchronous to sys_clk and
  that event inputs are levels held high while the condition lasts.
*/
//
// Behaviour
// - Counter reaching zero sets transfer-end flag
// - End-of-transfer pin also sets transfer-end flag
// - Iso buffer one completion sets bit 2
// - Iso buffer zero completion sets bit 1
// - Frame start sets bit 0
// - Mask has enables for bits 9..0
// - Enables combine with global enable bit
// - Mask clears to zero at power-on
// - Mask bit one enables, zero blocks
// - Mask read 25h, written A5h
// - Mask bits 9,8,7 gate dual-role, async, periodic
// - Mask bits 6,5 gate clock, suspend
// - Mask bit 4 gates operational event
// - Mask bits 3..0 gate transfer, iso, frame
// - Mask bits 15..10 reserved, read zero
// - Dual-role event sets bit 9
// - Async list threshold or timeout sets bit 8
// - Periodic list done with ack sets bit 7
// - Wake with clock running sets bit 6
`timescale 1ns/100ps
`default_nettype none
`include "hcif_consts.svh"
module hcif_irq_ctrl #(
  parameter int FLAG_W = 10
) (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // Processor command port.
  input  wire logic        cmd_rd_stb,
  input  wire logic        cmd_wr_stb,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  output logic      [15:0] cmd_rdata,
  output logic             cmd_rvalid,
  // Global enable from the hardware setup register.
  input  wire logic [15:0] hw_setup_reg,
  // Host event sources, levels.
  input  wire logic        transfer_count_zero,
  input  wire logic        end_of_transfer_pin,
  input  wire logic        iso_buffer_one_last_done,
  input  wire logic        iso_buffer_zero_last_done,
  input  wire logic        frame_start_state,
  input  wire logic        operational_event,
  input  wire logic        host_suspended,
  input  wire logic        clock_restored,
  input  wire logic        periodic_list_acked,
  input  wire logic        async_threshold_hit,
  input  wire logic        async_timeout_hit,
  input  wire logic        dual_role_event,
  // Interrupt and state view.
  output logic             irq_output_one,
  output logic      [15:0] cpu_irq_event_flags,
  output logic      [15:0] cpu_irq_enable_mask
);
  typedef struct packed {
    hcif_pkg::hcif_word_t    mask;
    hcif_pkg::hcif_word_t    flags;
    hcif_pkg::hcif_word_t    rdata;
    logic                    rvalid;
    logic                    irq;
    hcif_pkg::hcif_cmd_e     last_cmd;
  } hcif_ctrl_s;

  hcif_ctrl_s           state_q;
  hcif_ctrl_s           state_d;
  logic [1:0]           rst_sync_q;
  logic                 rst_sync_b;
  logic [FLAG_W-1:0]    ev_level;
  logic [FLAG_W-1:0]    ev_rise;
  hcif_pkg::hcif_word_t set_bits;
  hcif_pkg::hcif_word_t clr_bits;
  hcif_pkg::hcif_word_t read_word;
  logic                 global_en;
  logic                 mask_wr_hit;
  logic                 flags_wr_hit;
  logic                 mask_rd_hit;
  logic                 flags_rd_hit;
  logic                 frame_start_req;
  logic                 iso_zero_req;
  logic                 iso_one_req;
  logic                 transfer_end_req;
  logic                 operational_req;
  logic                 suspended_req;
  logic                 clock_req;
  logic                 periodic_req;
  logic                 async_req;
  logic                 dual_role_req;
  logic                 any_req;

  // Keeps only the implemented flag and enable positions, bits 9..0.
  function automatic hcif_pkg::hcif_word_t live_bits(input hcif_pkg::hcif_word_t w);
    live_bits = w & `HCIF_LIVE_BITS;
  endfunction

  // Places the event pulses at their flag positions in a register word.
  function automatic hcif_pkg::hcif_word_t widen_events(input logic [FLAG_W-1:0] ev);
    widen_events = 16'h0000;
    widen_events[FLAG_W-1:0] = ev;
  endfunction

  // A write of one clears a flag, but an event in the same cycle wins.
  function automatic hcif_pkg::hcif_word_t merge_flags(
    input hcif_pkg::hcif_word_t cur_w,
    input hcif_pkg::hcif_word_t clr_w,
    input hcif_pkg::hcif_word_t set_w
  );
    merge_flags = live_bits((cur_w & ~clr_w) | set_w);
  endfunction

  // True when a command strobe carries the wanted code.
  function automatic logic code_hit(input logic stb, input logic [7:0] code, input logic [7:0] want);
    code_hit = stb && (code == want);
  endfunction

  // Codes that this block does not own read as zero.
  function automatic hcif_pkg::hcif_word_t read_select(
    input logic                 mask_sel,
    input logic                 flags_sel,
    input hcif_pkg::hcif_word_t mask_w,
    input hcif_pkg::hcif_word_t flags_w
  );
    read_select = 16'h0000;
    if (mask_sel) begin
      read_select = mask_w;
    end else if (flags_sel) begin
      read_select = flags_w;
    end
  endfunction

  assign rst_sync_b = rst_sync_q[1];

  assign mask_wr_hit  = code_hit(cmd_wr_stb, cmd_code, `HCIF_CMD_MASK_WR);
  assign flags_wr_hit = code_hit(cmd_wr_stb, cmd_code, `HCIF_CMD_FLAGS_WR);
  assign mask_rd_hit  = code_hit(cmd_rd_stb, cmd_code, `HCIF_CMD_MASK_RD);
  assign flags_rd_hit = code_hit(cmd_rd_stb, cmd_code, `HCIF_CMD_FLAGS_RD);
  assign global_en    = hw_setup_reg[`HCIF_GLOBAL_EN_BIT];

  // Each flag asks for the interrupt only through its own enable bit.
  assign frame_start_req  = state_q.flags[`HCIF_BIT_FRAME] & state_q.mask[`HCIF_BIT_FRAME];
  assign iso_zero_req     = state_q.flags[`HCIF_BIT_ISO0] & state_q.mask[`HCIF_BIT_ISO0];
  assign iso_one_req      = state_q.flags[`HCIF_BIT_ISO1] & state_q.mask[`HCIF_BIT_ISO1];
  assign transfer_end_req = state_q.flags[`HCIF_BIT_XFER_END] & state_q.mask[`HCIF_BIT_XFER_END];
  assign operational_req  = state_q.flags[`HCIF_BIT_OPER] & state_q.mask[`HCIF_BIT_OPER];
  assign suspended_req    = state_q.flags[`HCIF_BIT_SUSPEND] & state_q.mask[`HCIF_BIT_SUSPEND];
  assign clock_req        = state_q.flags[`HCIF_BIT_CLOCK] & state_q.mask[`HCIF_BIT_CLOCK];
  assign periodic_req     = state_q.flags[`HCIF_BIT_PERIODIC] & state_q.mask[`HCIF_BIT_PERIODIC];
  assign async_req        = state_q.flags[`HCIF_BIT_ASYNC] & state_q.mask[`HCIF_BIT_ASYNC];
  assign dual_role_req    = state_q.flags[`HCIF_BIT_DUAL_ROLE] & state_q.mask[`HCIF_BIT_DUAL_ROLE];
  assign any_req          = frame_start_req | iso_zero_req | iso_one_req | transfer_end_req |
                            operational_req | suspended_req | clock_req | periodic_req |
                            async_req | dual_role_req;

  // Event levels are collected at their flag positions.
  always_comb begin
    ev_level = '0;
    ev_level[`HCIF_BIT_XFER_END]  = transfer_count_zero | end_of_transfer_pin;
    ev_level[`HCIF_BIT_ISO1]      = iso_buffer_one_last_done;
    ev_level[`HCIF_BIT_ISO0]      = iso_buffer_zero_last_done;
    ev_level[`HCIF_BIT_FRAME]     = frame_start_state;
    ev_level[`HCIF_BIT_OPER]      = operational_event;
    ev_level[`HCIF_BIT_SUSPEND]   = host_suspended;
    ev_level[`HCIF_BIT_CLOCK]     = clock_restored;
    ev_level[`HCIF_BIT_PERIODIC]  = periodic_list_acked;
    ev_level[`HCIF_BIT_ASYNC]     = async_threshold_hit | async_timeout_hit;
    ev_level[`HCIF_BIT_DUAL_ROLE] = dual_role_event;
  end

  hcif_event_edge #(
    .WIDTH (FLAG_W)
  ) u_edge (
    .sys_clk    (sys_clk),
    .rst_sync_b (rst_sync_b),
    .level_in   (ev_level),
    .rise_out   (ev_rise)
  );

  // Set requests, clear requests and the read word of this cycle.
  always_comb begin
    set_bits = widen_events(ev_rise);
    clr_bits = 16'h0000;
    if (flags_wr_hit) begin
      clr_bits = live_bits(cmd_wdata);
    end
    read_word = read_select(mask_rd_hit, flags_rd_hit, state_q.mask, state_q.flags);
  end

  always_comb begin
    state_d = state_q;
    state_d.rvalid = 1'b0;
    state_d.last_cmd = hcif_pkg::HCIF_IDLE;
    if (cmd_wr_stb) begin
      state_d.last_cmd = hcif_pkg::HCIF_WRITE;
    end
    if (mask_wr_hit) begin
      state_d.mask = live_bits(cmd_wdata);
    end
    state_d.flags = merge_flags(state_q.flags, clr_bits, set_bits);
    if (cmd_rd_stb) begin
      state_d.last_cmd = hcif_pkg::HCIF_READ;
      state_d.rvalid = 1'b1;
      state_d.rdata = read_word;
    end
    state_d.irq = global_en & any_req;
  end

  // The synchroniser keeps its own register so that it alone sees the raw reset.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_q.mask     <= `HCIF_MASK_RESET;
      state_q.flags    <= `HCIF_FLAGS_RESET;
      state_q.rdata    <= 16'h0000;
      state_q.rvalid   <= 1'b0;
      state_q.irq      <= 1'b0;
      state_q.last_cmd <= hcif_pkg::HCIF_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign irq_output_one      = state_q.irq;
  assign cmd_rdata           = state_q.rdata;
  assign cmd_rvalid          = state_q.rvalid;
  assign cpu_irq_event_flags = state_q.flags;
  assign cpu_irq_enable_mask = state_q.mask;
endmodule
`default_nettype wire

// ---- core/hcif_consts.svh ----
/*
  Constants of the host interrupt flag and mask block: command codes, bit positions, reset values.
  Assumes inclusion by bare name from the design files.
*/
`ifndef HCIF_CONSTS_SVH
`define HCIF_CONSTS_SVH

`define HCIF_CMD_MASK_RD     8'h25
`define HCIF_CMD_MASK_WR     8'hA5
`define HCIF_CMD_FLAGS_RD    8'h24
`define HCIF_CMD_FLAGS_WR    8'hA4
`define HCIF_BIT_FRAME       0
`define HCIF_BIT_ISO0        1
`define HCIF_BIT_ISO1        2
`define HCIF_BIT_XFER_END    3
`define HCIF_BIT_OPER        4
`define HCIF_BIT_SUSPEND     5
`define HCIF_BIT_CLOCK       6
`define HCIF_BIT_PERIODIC    7
`define HCIF_BIT_ASYNC       8
`define HCIF_BIT_DUAL_ROLE   9
`define HCIF_LIVE_BITS       16'h03FF
`define HCIF_MASK_RESET      16'h0000
`define HCIF_FLAGS_RESET     16'h0000
`define HCIF_GLOBAL_EN_BIT   0

`endif

// ---- core/hcif_pkg.sv ----
/*
  Types shared by the host interrupt flag and mask block.
  Assumes the constants header is compiled alongside.
*/
package hcif_pkg;
  typedef logic [15:0] hcif_word_t;
  typedef enum logic [1:0] {
    HCIF_IDLE,
    HCIF_READ,
    HCIF_WRITE
  } hcif_cmd_e;
endpackage

// ---- core/hcif_event_edge.sv ----
/*
  Rising edge detector that turns an event level into a one-cycle set pulse.
  Assumes a level synchronous to sys_clk and a synchronised active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module hcif_event_edge #(
  parameter int WIDTH = 10
) (
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             rst_sync_b,
  // Event levels and their rising edges.
  input  wire logic [WIDTH-1:0] level_in,
  output logic      [WIDTH-1:0] rise_out
);
  typedef struct packed {
    logic [WIDTH-1:0] prev;
  } hcif_edge_s;

  hcif_edge_s state_q;
  hcif_edge_s state_d;

  always_comb begin
    state_d.prev = level_in;
  end

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign rise_out = level_in & ~state_q.prev;
endmodule
`default_nettype wire

// ---- testbench/hcif_irq_ctrl_assertions.sv ----
/* Checker for the interrupt flag and mask block.
   Bound to the design top, sees its ports only. */
`timescale 1ns/100ps
`default_nettype none
module hcif_irq_chk (
  // Clock and reset.
  input wire logic        sys_clk,
  input wire logic        rst_b,
  // Command port, events and state.
  input wire logic        cmd_rd_stb,
  input wire logic        cmd_wr_stb,
  input wire logic [7:0]  cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic [15:0] cmd_rdata,
  input wire logic        cmd_rvalid,
  input wire logic [15:0] hw_setup_reg,
  input wire logic        frame_start_state,
  input wire logic        dual_role_event,
  input wire logic        irq_output_one,
  input wire logic [15:0] cpu_irq_event_flags,
  input wire logic [15:0] cpu_irq_enable_mask
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_mwr; cmd_wr_stb && cmd_code == 8'hA5; endsequence
  sequence s_dual; !dual_role_event ##1 dual_role_event; endsequence
  a_mask_reset: assert property ($rose(rst_b) |-> cpu_irq_enable_mask == 16'h0000)
    else $error("mask not clear after reset");
  a_mask_write: assert property (s_mwr |=> cpu_irq_enable_mask == ($past(cmd_wdata) & 16'h03FF))
    else $error("mask write lost");
  a_mask_hold: assert property (!(cmd_wr_stb && cmd_code == 8'hA5) |=> $stable(cpu_irq_enable_mask))
    else $error("mask changed without write");
  a_mask_read: assert property (cmd_rd_stb && cmd_code == 8'h25 |=> cmd_rvalid
    && cmd_rdata == $past(cpu_irq_enable_mask))
    else $error("mask read wrong");
  a_rsv_zero: assert property (cpu_irq_enable_mask[15:10] == 6'h00)
    else $error("reserved mask bits set");
  a_irq_follows: assert property (irq_output_one == $past(hw_setup_reg[0]
    && |(cpu_irq_event_flags & cpu_irq_enable_mask)))
    else $error("interrupt output wrong");
  a_frame_flag: assert property ($rose(frame_start_state) |=> cpu_irq_event_flags[0])
    else $error("frame flag not set");
  a_dual_flag: assert property (s_dual |=> cpu_irq_event_flags[9])
    else $error("dual role flag not set");
endmodule
`default_nettype wire

// ---- testbench/hcif_cpu_model.sv ----
/* Processor model issuing one command at a time.
   Assumes it is called once reset has cleared. */
`timescale 1ns/100ps
`default_nettype none
// Setup and buffer state codes belong to other blocks; this one ignores them.
module hcif_cpu_model #(
  parameter logic [7:0] BUF_STATE_RD = 8'h2C,
  parameter logic [7:0] DMA_SETUP_WR = 8'h00
) (
  // Clock.
  input wire logic        sys_clk,
  // Command port.
  output var logic        cmd_rd_stb,
  output var logic        cmd_wr_stb,
  output var logic [7:0]  cmd_code,
  output var logic [15:0] cmd_wdata,
  input wire logic [15:0] cmd_rdata,
  input wire logic        cmd_rvalid,
  output var logic [15:0] rd_word
);
  initial {cmd_rd_stb, cmd_wr_stb, cmd_code, cmd_wdata, rd_word} = '0;
  // Idle code and data lines show the inverse value so stale data is never mistaken.
  task automatic xfer(input logic rd, input logic [7:0] c, input logic [15:0] d);
    @(posedge sys_clk);
    #1 {cmd_rd_stb, cmd_wr_stb, cmd_code, cmd_wdata} = {rd, !rd, c, d};
    @(posedge sys_clk);
    #1 {cmd_rd_stb, cmd_wr_stb, cmd_code, cmd_wdata} = {2'b00, ~c, ~d};
    if (rd) rd_word = cmd_rvalid ? cmd_rdata : 16'hXXXX;
  endtask
  // Before iso data is fetched, the DMA setup is written and the buffer state read.
  task automatic iso_prepare();
    xfer(0, DMA_SETUP_WR, 16'h0000);
    xfer(1, BUF_STATE_RD, 16'h0000);
  endtask
endmodule
`default_nettype wire

// ---- testbench/hcif_irq_ctrl_bench.sv ----
/* Bench for the interrupt flag and mask block.
   Assumes checker and processor model compiled first. */
`timescale 1ns/100ps
`default_nettype none
module hcif_irq_ctrl_bench;
  logic        sys_clk = 0;
  logic        rst_b = 0;
  logic [15:0] hw_setup_reg = 16'h0001;
  logic [11:0] ev = '0;
  logic        cmd_rd_stb, cmd_wr_stb, cmd_rvalid, irq_output_one;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata, rd_word, cpu_irq_event_flags, cpu_irq_enable_mask;
  int          n_mismatch = 0;
  int          n_checks = 0;
  // Expected flag word for each event input, in port order.
  logic [15:0] row_exp [12] = '{16'h0008, 16'h0008, 16'h0004, 16'h0002, 16'h0001, 16'h0010,
                                16'h0020, 16'h0040, 16'h0080, 16'h0100, 16'h0100, 16'h0200};
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
  hcif_cpu_model u_cpu (
    .sys_clk    (sys_clk),
    .cmd_rd_stb (cmd_rd_stb),
    .cmd_wr_stb (cmd_wr_stb),
    .cmd_code   (cmd_code),
    .cmd_wdata  (cmd_wdata),
    .cmd_rdata  (cmd_rdata),
    .cmd_rvalid (cmd_rvalid),
    .rd_word    (rd_word)
  );
  hcif_irq_ctrl dut (
    .sys_clk                   (sys_clk),
    .rst_b                     (rst_b),
    .cmd_rd_stb                (cmd_rd_stb),
    .cmd_wr_stb                (cmd_wr_stb),
    .cmd_code                  (cmd_code),
    .cmd_wdata                 (cmd_wdata),
    .cmd_rdata                 (cmd_rdata),
    .cmd_rvalid                (cmd_rvalid),
    .hw_setup_reg              (hw_setup_reg),
    .transfer_count_zero       (ev[0]),
    .end_of_transfer_pin       (ev[1]),
    .iso_buffer_one_last_done  (ev[2]),
    .iso_buffer_zero_last_done (ev[3]),
    .frame_start_state         (ev[4]),
    .operational_event         (ev[5]),
    .host_suspended            (ev[6]),
    .clock_restored            (ev[7]),
    .periodic_list_acked       (ev[8]),
    .async_threshold_hit       (ev[9]),
    .async_timeout_hit         (ev[10]),
    .dual_role_event           (ev[11]),
    .irq_output_one            (irq_output_one),
    .cpu_irq_event_flags       (cpu_irq_event_flags),
    .cpu_irq_enable_mask       (cpu_irq_enable_mask)
  );
  initial forever #5 sys_clk = ~sys_clk;
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge sys_clk);
    n_mismatch++;
    stop_test;
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    #1 rst_b = 1;
    tick(3);
    u_cpu.xfer(1, 8'h25, 16'h0000);
    `CHK("mask reset", 16'h0000, rd_word)
    u_cpu.xfer(0, 8'hA5, 16'hFFFF);
    u_cpu.xfer(1, 8'h25, 16'h0000);
    `CHK("mask rsv", 16'h03FF, rd_word)
    for (int i = 0; i < 12; i++) begin
      u_cpu.xfer(0, 8'hA5, ~row_exp[i]);
      ev[i] = 1;
      tick(2);
      `CHK("flags", row_exp[i], cpu_irq_event_flags)
      `CHK("irq off", 1'b0, irq_output_one)
      u_cpu.xfer(1, 8'h24, 16'h0000);
      `CHK("flags rd", row_exp[i], rd_word)
      if (i >= 2 && i <= 4) begin
        u_cpu.iso_prepare();
        `CHK("buf state", 16'h0000, rd_word)
      end
      u_cpu.xfer(0, 8'hA5, row_exp[i]);
      tick(1);
      `CHK("irq on", 1'b1, irq_output_one)
      u_cpu.xfer(0, 8'hA4, 16'hFFFF);
      tick(1);
      `CHK("held", 16'h0000, cpu_irq_event_flags)
      ev[i] = 0;
    end
    hw_setup_reg = 16'h0000;
    u_cpu.xfer(0, 8'hA5, 16'h0001);
    ev[4] = 1;
    tick(3);
    `CHK("global off", 1'b0, irq_output_one)
    hw_setup_reg = 16'h0001;
    tick(1);
    `CHK("global on", 1'b1, irq_output_one)
    u_cpu.xfer(1, 8'h26, 16'h0000);
    `CHK("unmapped", 16'h0000, rd_word)
    ev[4] = 0;
    u_cpu.xfer(0, 8'hA4, 16'hFFFF);
    fork
      u_cpu.xfer(0, 8'hA4, 16'hFFFF);
      begin
        @(posedge sys_clk);
        #1 ev[4] = 1;
      end
    join
    `CHK("set wins", 16'h0001, cpu_irq_event_flags)
    stop_test;
  end
endmodule
bind hcif_irq_ctrl hcif_irq_chk u_chk (
  .sys_clk             (sys_clk),
  .rst_b               (rst_b),
  .cmd_rd_stb          (cmd_rd_stb),
  .cmd_wr_stb          (cmd_wr_stb),
  .cmd_code            (cmd_code),
  .cmd_wdata           (cmd_wdata),
  .cmd_rdata           (cmd_rdata),
  .cmd_rvalid          (cmd_rvalid),
  .hw_setup_reg        (hw_setup_reg),
  .frame_start_state   (frame_start_state),
  .dual_role_event     (dual_role_event),
  .irq_output_one      (irq_output_one),
  .cpu_irq_event_flags (cpu_irq_event_flags),
  .cpu_irq_enable_mask (cpu_irq_enable_mask)
);
`default_nettype wire
